// ---- rtl/wtc_pkg.sv ----
package wtc_pkg;
    // Widths
    localparam int DW  = 18;
    localparam int AW  = 14;
    localparam int RW  = 21;
    localparam int OW  = 7;
    localparam int BW  = 8;
    localparam int WTW = 10;

    // Word time
    localparam int CLK_PERIOD_NS = 10;
    localparam int WORD_TIME_NS  = 6940;
    localparam int WORD_CYCLES   = (WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Operation codes, instruction word bits 17..11
    localparam logic [OW-1:0] OP_LDA  = 7'h41;
    localparam logic [OW-1:0] OP_STB  = 7'h52;
    localparam logic [OW-1:0] OP_AMA  = 7'h44;
    localparam logic [OW-1:0] OP_LDQ  = 7'h46;
    localparam logic [OW-1:0] OP_SR1  = 7'h01;
    localparam logic [OW-1:0] OP_DIF  = 7'h02;
    localparam logic [OW-1:0] OP_XMT  = 7'h03;
    localparam logic [OW-1:0] OP_HALT = 7'h04;

    // Instruction fields
    localparam int OP_LSB   = 11;
    localparam int MODE_BIT = 10;
    localparam int ADDR_FW  = 10;
    localparam int DIF_VAL  = 4;

    // Internal function driver numbers
    localparam logic [3:0] DIF_PAR    = 4'h0;
    localparam logic [3:0] DIF_HWLOAD = 4'h4;
    localparam logic [3:0] DIF_CTL1   = 4'h8;
    localparam logic [3:0] DIF_CTL2   = 4'h9;

    // Elapsed counter restart value (-32)
    localparam logic [AW-1:0] Q_RESTART = 14'h3fe0;

    // Tape level codes
    localparam logic [1:0] LVL_8 = 2'h3;
    localparam int TAPE_BITS = 6;

    // Parity sense: 1 gives odd parity over 21 bits
    localparam logic PAR_ODD = 1'b1;

    // Register offsets
    localparam logic [BW-1:0] REG_CTRL = 8'h00;
    localparam logic [BW-1:0] REG_STAT = 8'h04;
    localparam logic [BW-1:0] REG_PC   = 8'h08;
    localparam logic [BW-1:0] REG_ACCA = 8'h0c;
    localparam logic [BW-1:0] REG_ACCB = 8'h10;
    localparam logic [BW-1:0] REG_TAPE = 8'h14;
    localparam logic [BW-1:0] REG_CIDX = 8'h18;

    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_OPER  = 1;
    localparam int CTRL_QEN   = 2;
    localparam int CTRL_LVL   = 3;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_EXEC  = 2'b10,
        ST_LOAD  = 2'b11
    } state_t;
endpackage

// ---- rtl/word_time_cycle_sequencer.sv ----
`timescale 1ns/1ps
// What this block does
// [RULE1] Receive lines 19-21 load the three control flags
// [RULE2] Third control flag doubles as word parity bit
// [RULE3] Flags one and two set, parity drives line 21
// [RULE4] Each cycle lasts exactly one word time
// [RULE5] Copy counter to address first, then increment counter
// [RULE6] Address drives memory; fetched word decoded as opcode
// [RULE7] Memory reference: effective address into address register
// [RULE8] Instruction fetch rewrites the fetched word
// [RULE9] Load first accumulator from memory, regenerate, flags
// [RULE10] Store second accumulator via operand register, flags
// [RULE11] Add memory into first accumulator, regenerate, flags
// [RULE12] Shift right OR of accumulator and receive lines
// [RULE13] Tape char into buffer zero, sets receive flag
// [RULE14] Program mode any level; hardware load only 8-level
// [RULE15] Hardware load copies tape into memory, no execution
// [RULE16] Console load control starts hardware load
// [RULE17] Internal function driver 4 starts hardware load
// [RULE18] Elapsed counter reaching -32 starts hardware load
// [RULE19] Second counter load between interrupts starts load; the block does so in operate mode only
// [RULE20] Halt in operate mode starts hardware load
// [RULE21] Branch flags take sign, zero and odd
// [RULE22] Parity over second accumulator and flags one, two
// [RULE23] Elapsed counter decrements each word time once loaded
// [RULE24] Memory-reference instructions alternate instruction and execution cycles
module word_time_cycle_sequencer #(
    parameter int WORD_CYCLES = wtc_pkg::WORD_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_i,
    // Register port
    input  wire logic [wtc_pkg::BW-1:0]  reg_addr_i,
    input  wire logic [31:0]             reg_wdata_i,
    input  wire logic                    reg_we_i,
    input  wire logic                    reg_re_i,
    output logic      [31:0]             reg_rdata_o,
    // Core memory
    output logic      [wtc_pkg::AW-1:0]  mem_addr_o,
    input  wire logic [wtc_pkg::DW-1:0]  mem_rdata_i,
    output logic                         mem_we_o,
    output logic      [wtc_pkg::AW-1:0]  mem_waddr_o,
    output logic      [wtc_pkg::DW-1:0]  mem_wdata_o,
    // Buffer selector
    input  wire logic [wtc_pkg::RW-1:0]  rx_i,
    output logic      [wtc_pkg::RW-1:0]  tx_o,
    output logic                         tx_strobe_o,
    output logic      [wtc_pkg::OW-1:0]  buf_addr_o,
    // Paper tape reader and console
    input  wire logic                    tape_valid_i,
    input  wire logic [7:0]              tape_char_i,
    input  wire logic [1:0]              tape_level_i,
    input  wire logic                    tape_end_i,
    output logic                         tape_flag_o,
    input  wire logic                    console_load_i,
    // Status
    output logic                         prog_int_o,
    output logic                         hw_load_o
);
    import wtc_pkg::*;

    state_t        state_q;
    logic [WTW-1:0] wt_q;
    logic          tick;
    logic [AW-1:0] pc_q, addr_q, q_q, q_dec, ea;
    logic [DW-1:0] acc_a_q, acc_b_q, y_q, y_d, z, word;
    logic [OW-1:0] op, op_q, c_q;
    logic          general, upd, load_go, start, word_par;
    logic          in_instr, in_exec, sr1_now, dif_now, xmt_now;
    logic          sign_q, zero_q, odd_q, ctl1_q, ctl2_q, par_q;
    logic          q_run_q, ldq_seen_q, oper_q, qen_q, q_restart, q_zero;
    logic [1:0]    lvl_q, chr_cnt_q;
    logic [7:0]    tape_buf_q;
    logic          tape_flag_q, chr_ok, word_done;
    logic [11:0]   asm_q;
    logic [RW-1:0] tx_q;
    logic          tx_stb_q, int_q, we_q;
    logic [AW-1:0] waddr_q;
    logic [DW-1:0] wdata_q;
    logic [31:0]   rdata_q;

    // Word time base
    assign tick = (wt_q == WTW'(WORD_CYCLES - 1));
    always_ff @(posedge core_clk_i) begin
        // A new run or a finished load begins with a full word time
        if (rst_i || tick || (start && state_q == ST_IDLE) || state_q == ST_LOAD) begin
            wt_q <= '0;
        end else begin
            wt_q <= wt_q + 10'h1; // [RULE4]
        end
    end

    // Decode of the word in the memory output register
    assign word     = mem_rdata_i;
    assign op       = word[DW-1:OP_LSB]; // [RULE6]
    assign general  = (op[6:4] == 3'h0);
    assign in_instr = (state_q == ST_INSTR) && tick;
    assign in_exec  = (state_q == ST_EXEC) && tick;
    assign sr1_now  = in_instr && (op == OP_SR1);
    assign dif_now  = in_instr && (op == OP_DIF);
    assign xmt_now  = in_instr && (op == OP_XMT);
    assign ea = word[MODE_BIT] ? AW'({4'h0, word[ADDR_FW-1:0]} + {7'h0, c_q})
                               : {pc_q[AW-1:ADDR_FW], word[ADDR_FW-1:0]}; // [RULE7]
    assign word_par = ^{acc_b_q, ctl2_q, ctl1_q} ^ PAR_ODD; // [RULE22]
    assign q_dec    = q_q - 14'h1;
    assign q_restart = tick && q_run_q && qen_q && (q_dec == Q_RESTART);
    assign q_zero    = tick && q_run_q && qen_q && (q_dec == '0);
    assign start = reg_we_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_START];

    // Operand register and result drivers
    always_comb begin
        y_d = y_q;
        z   = '0;
        upd = 1'b0;
        if (sr1_now) begin
            y_d = acc_b_q | rx_i[DW-1:0];
            z   = y_d >> 1; // [RULE12]
            upd = 1'b1;
        end else if (in_instr && !general) begin
            z = {4'h0, ea};
        end else if (in_exec) begin
            upd = 1'b1;
            case (op_q)
                OP_LDA: z = word; // [RULE9]
                OP_STB: begin
                    y_d = acc_b_q;
                    z   = y_d; // [RULE10]
                end
                OP_AMA: begin
                    y_d = acc_a_q;
                    z   = y_d + word; // [RULE11]
                end
                default: z = word;
            endcase
        end
    end

    // Hardware load triggers
    always_comb begin
        load_go = console_load_i; // [RULE16]
        if (dif_now && word[3:0] == DIF_HWLOAD && word[DIF_VAL]) begin
            load_go = 1'b1; // [RULE17]
        end
        if (q_restart) begin
            load_go = 1'b1; // [RULE18]
        end
        if (in_exec && op_q == OP_LDQ && oper_q && ldq_seen_q) begin
            load_go = 1'b1; // [RULE19]
        end
        if (in_instr && op == OP_HALT && oper_q) begin
            load_go = 1'b1; // [RULE20]
        end
        if (state_q == ST_LOAD) begin
            load_go = 1'b0;
        end
    end

    // Tape character acceptance during hardware load
    assign chr_ok    = (state_q == ST_LOAD) && tape_valid_i && (tape_level_i == LVL_8); // [RULE14]
    assign word_done = chr_ok && (chr_cnt_q == 2'h2);

    // Sequencing, program counter and memory address
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            pc_q    <= '0;
            addr_q  <= '0;
            op_q    <= '0;
        end else if (load_go) begin
            state_q <= ST_LOAD;
            addr_q  <= '0; // [RULE15]
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_INSTR;
                        addr_q  <= pc_q;
                    end else if (reg_we_i && reg_addr_i == REG_PC) begin
                        pc_q <= reg_wdata_i[AW-1:0];
                    end
                end
                ST_INSTR: begin
                    if (tick) begin
                        op_q <= op; // [RULE6]
                        pc_q <= pc_q + 14'h1; // [RULE5]
                        if (!general) begin
                            addr_q  <= ea; // [RULE7]
                            state_q <= ST_EXEC; // [RULE24]
                        end else if (op == OP_HALT) begin
                            state_q <= ST_IDLE;
                        end else begin
                            addr_q <= pc_q + 14'h1; // [RULE5]
                        end
                    end
                end
                ST_EXEC: begin
                    if (tick) begin
                        addr_q  <= pc_q; // [RULE5]
                        state_q <= ST_INSTR; // [RULE24]
                    end
                end
                ST_LOAD: begin
                    if (tape_end_i) begin
                        state_q <= ST_INSTR;
                        pc_q    <= '0;
                        addr_q  <= '0;
                    end else if (word_done) begin
                        addr_q <= addr_q + 14'h1; // [RULE15]
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Memory write: regeneration, store and hardware load
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            we_q    <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
        end else begin
            we_q <= 1'b0;
            if (word_done) begin
                we_q    <= 1'b1;
                waddr_q <= addr_q;
                wdata_q <= {asm_q, tape_char_i[TAPE_BITS-1:0]}; // [RULE15]
            end else if (in_instr || in_exec) begin
                we_q    <= 1'b1;
                waddr_q <= addr_q;
                wdata_q <= (in_exec && op_q == OP_STB) ? z : word; // [RULE8] [RULE10]
            end
        end
    end

    // Accumulators and operand register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_a_q <= '0;
            acc_b_q <= '0;
            y_q     <= '0;
            c_q     <= '0;
        end else begin
            y_q <= y_d;
            if (in_exec && (op_q == OP_LDA || op_q == OP_AMA)) begin
                acc_a_q <= z; // [RULE9] [RULE11]
            end else if (state_q == ST_IDLE && reg_we_i && reg_addr_i == REG_ACCA) begin
                acc_a_q <= reg_wdata_i[DW-1:0];
            end
            if (sr1_now) begin
                acc_b_q <= z; // [RULE12]
            end else if (state_q == ST_IDLE && reg_we_i && reg_addr_i == REG_ACCB) begin
                acc_b_q <= reg_wdata_i[DW-1:0];
            end
            if (reg_we_i && reg_addr_i == REG_CIDX) begin
                c_q <= reg_wdata_i[OW-1:0];
            end
        end
    end

    // Branch flags
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sign_q <= 1'b0;
            zero_q <= 1'b0;
            odd_q  <= 1'b0;
        end else if (upd) begin
            sign_q <= z[DW-1]; // [RULE21]
            zero_q <= (z == '0); // [RULE21]
            odd_q  <= z[0]; // [RULE21]
        end
    end

    // Control flags and transmit lines
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctl1_q   <= 1'b0;
            ctl2_q   <= 1'b0;
            par_q    <= 1'b0;
            tx_q     <= '0;
            tx_stb_q <= 1'b0;
        end else begin
            tx_stb_q <= xmt_now;
            if (sr1_now) begin
                {par_q, ctl2_q, ctl1_q} <= rx_i[RW-1:DW]; // [RULE1]
            end else if (dif_now) begin
                case (word[3:0])
                    DIF_CTL1: ctl1_q <= word[DIF_VAL]; // [RULE3]
                    DIF_CTL2: ctl2_q <= word[DIF_VAL]; // [RULE3]
                    DIF_PAR:  par_q  <= word[DIF_VAL];
                    default:  par_q  <= par_q;
                endcase
            end else if (xmt_now) begin
                par_q <= word_par; // [RULE2]
                tx_q  <= {word_par, ctl2_q, ctl1_q, acc_b_q}; // [RULE3]
            end
        end
    end

    // Elapsed counter and interrupt
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q_q        <= '0;
            q_run_q    <= 1'b0;
            ldq_seen_q <= 1'b0;
            int_q      <= 1'b0;
        end else begin
            int_q <= q_zero;
            if (load_go) begin
                q_run_q    <= 1'b0;
                ldq_seen_q <= 1'b0;
            end else begin
                if (in_exec && op_q == OP_LDQ) begin
                    q_q     <= word[AW-1:0];
                    q_run_q <= 1'b1;
                end else if (tick && q_run_q) begin
                    q_q <= q_dec; // [RULE23]
                end
                if (q_zero) begin
                    ldq_seen_q <= 1'b0;
                end
                if (in_exec && op_q == OP_LDQ) begin
                    ldq_seen_q <= 1'b1; // [RULE19]
                end
            end
        end
    end

    // Tape reader: buffer zero and hardware-load assembly
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tape_buf_q  <= '0;
            tape_flag_q <= 1'b0;
            chr_cnt_q   <= '0;
            asm_q       <= '0;
        end else begin
            if (reg_re_i && reg_addr_i == REG_TAPE) begin
                tape_flag_q <= 1'b0;
            end
            if (state_q != ST_LOAD && tape_valid_i) begin
                tape_buf_q  <= tape_char_i & (8'hff >> (2'h3 - lvl_q)); // [RULE14]
                tape_flag_q <= 1'b1; // [RULE13]
            end
            if (state_q != ST_LOAD) begin
                chr_cnt_q <= '0;
            end else if (chr_ok) begin
                chr_cnt_q <= word_done ? 2'h0 : chr_cnt_q + 2'h1;
                asm_q     <= {asm_q[5:0], tape_char_i[TAPE_BITS-1:0]};
            end
        end
    end

    // Control register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            oper_q <= 1'b0;
            qen_q  <= 1'b0;
            lvl_q  <= LVL_8;
        end else if (reg_we_i && reg_addr_i == REG_CTRL) begin
            oper_q <= reg_wdata_i[CTRL_OPER];
            qen_q  <= reg_wdata_i[CTRL_QEN];
            lvl_q  <= reg_wdata_i[CTRL_LVL+1:CTRL_LVL];
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !reg_re_i) begin
            rdata_q <= '0;
        end else begin
            case (reg_addr_i)
                REG_CTRL: rdata_q <= {27'h0, lvl_q, qen_q, oper_q, 1'b0};
                REG_STAT: rdata_q <= {22'h0, state_q, q_run_q, tape_flag_q, par_q,
                                      ctl2_q, ctl1_q, odd_q, zero_q, sign_q};
                REG_PC:   rdata_q <= {18'h0, pc_q};
                REG_ACCA: rdata_q <= {14'h0, acc_a_q};
                REG_ACCB: rdata_q <= {14'h0, acc_b_q};
                REG_TAPE: rdata_q <= {24'h0, tape_buf_q};
                REG_CIDX: rdata_q <= {25'h0, c_q};
                default:  rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign mem_addr_o  = addr_q; // [RULE6]
    assign mem_we_o    = we_q;
    assign mem_waddr_o = waddr_q;
    assign mem_wdata_o = wdata_q;
    assign tx_o        = tx_q;
    assign tx_strobe_o = tx_stb_q;
    assign buf_addr_o  = c_q;
    assign tape_flag_o = tape_flag_q;
    assign prog_int_o  = int_q;
    assign hw_load_o   = (state_q == ST_LOAD);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_fetch_order;
        in_instr && !load_go |-> addr_q == pc_q ##1 pc_q == $past(pc_q) + 14'h1;
    endproperty
    a_fetch_order: assert property (p_fetch_order) else $error("fetch order"); // [RULE5]

    property p_word_time;
        (state_q == ST_INSTR || state_q == ST_EXEC) && !tick && !load_go |=> $stable(state_q);
    endproperty
    a_word_time: assert property (p_word_time) else $error("cycle ends early"); // [RULE4]

    property p_alternate;
        in_exec && !load_go |=> state_q == ST_INSTR && addr_q == pc_q;
    endproperty
    a_alternate: assert property (p_alternate) else $error("no alternation"); // [RULE24]

    property p_regen;
        in_instr |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i)
                     && mem_waddr_o == $past(addr_q);
    endproperty
    a_regen: assert property (p_regen) else $error("fetch not rewritten"); // [RULE8]

    property p_load_a;
        in_exec && op_q == OP_LDA |=> acc_a_q == $past(mem_rdata_i)
                                     && sign_q == acc_a_q[DW-1] && odd_q == acc_a_q[0];
    endproperty
    a_load_a: assert property (p_load_a) else $error("load wrong"); // [RULE9]

    property p_store_b;
        in_exec && op_q == OP_STB |=> mem_we_o && mem_wdata_o == $past(acc_b_q);
    endproperty
    a_store_b: assert property (p_store_b) else $error("store wrong"); // [RULE10]

    property p_add;
        in_exec && op_q == OP_AMA |=> acc_a_q == DW'($past(acc_a_q) + $past(mem_rdata_i))
                                     && zero_q == (acc_a_q == '0);
    endproperty
    a_add: assert property (p_add) else $error("add wrong"); // [RULE11]

    property p_shift;
        sr1_now |=> acc_b_q == (($past(acc_b_q) | $past(rx_i[DW-1:0])) >> 1)
                   && ctl1_q == $past(rx_i[DW]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong"); // [RULE12]

    property p_parity;
        tx_strobe_o |-> tx_o[RW-1] == (^tx_o[RW-2:0] ^ PAR_ODD) && par_q == tx_o[RW-1];
    endproperty
    a_parity: assert property (p_parity) else $error("parity wrong"); // [RULE22]

    property p_restart;
        q_restart && state_q != ST_LOAD |=> hw_load_o && !q_run_q;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart load"); // [RULE18]
endmodule

// ---- tb/core_mem_model.sv ----
`timescale 1ns/1ps
module core_mem_model
    import wtc_pkg::*;
(
    // Clock
    input  wire logic          core_clk_i,
    // Read side
    input  wire logic [AW-1:0] mem_addr_i,
    output logic      [DW-1:0] mem_rdata_o,
    // Write side
    input  wire logic          mem_we_i,
    input  wire logic [AW-1:0] mem_waddr_i,
    input  wire logic [DW-1:0] mem_wdata_i
);
    logic [DW-1:0] ram [0:(1<<AW)-1];

    // Word is presented while the address is held, well inside a word time
    assign mem_rdata_o = ram[mem_addr_i];

    // Plain always: the bench preloads the array as well
    always @(posedge core_clk_i) begin
        if (mem_we_i) begin
            ram[mem_waddr_i] <= mem_wdata_i;
        end
    end
endmodule

// ---- tb/word_time_cycle_sequencer_tb.sv ----
`timescale 1ns/1ps
module word_time_cycle_sequencer_tb;
    import wtc_pkg::*;
    logic          core_clk_i   = 1'b0;
    logic          rst_i        = 1'b1;
    logic [BW-1:0] reg_addr_i   = '0;
    logic [31:0]   reg_wdata_i  = '0;
    logic          reg_we_i     = 1'b0;
    logic          reg_re_i     = 1'b0;
    logic [31:0]   reg_rdata_o;
    logic [AW-1:0] mem_addr_o;
    logic [AW-1:0] mem_waddr_o;
    logic [DW-1:0] mem_rdata_i;
    logic [DW-1:0] mem_wdata_o;
    logic          mem_we_o;
    logic [RW-1:0] rx_i         = '0;
    logic [RW-1:0] tx_o;
    logic          tape_valid_i = 1'b0;
    logic [7:0]    tape_char_i  = '0;
    logic [1:0]    tape_level_i = LVL_8;
    logic          tape_end_i   = 1'b0;
    logic          console_load_i = 1'b0;
    logic          tape_flag_o;
    logic          hw_load_o;
    logic          tx_strobe_o;
    logic          prog_int_o;
    logic [OW-1:0] buf_addr_o;
    logic [31:0]   v;
    int            fails       = 0;
    int            checks_done = 0;
    int            cyc         = 0;
    int            int_cnt     = 0;
    int            stb_cnt     = 0;

    word_time_cycle_sequencer #(.WORD_CYCLES(4)) uut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
        .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
        .rx_i(rx_i), .tx_o(tx_o), .tx_strobe_o(tx_strobe_o), .buf_addr_o(buf_addr_o),
        .tape_valid_i(tape_valid_i), .tape_char_i(tape_char_i),
        .tape_level_i(tape_level_i), .tape_end_i(tape_end_i), .tape_flag_o(tape_flag_o),
        .console_load_i(console_load_i), .prog_int_o(prog_int_o), .hw_load_o(hw_load_o)
    );

    core_mem_model mem (
        .core_clk_i(core_clk_i), .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i),
        .mem_we_i(mem_we_o), .mem_waddr_i(mem_waddr_o), .mem_wdata_i(mem_wdata_o)
    );

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        int_cnt <= int_cnt + ((prog_int_o === 1'b1) ? 1 : 0);
        stb_cnt <= stb_cnt + ((tx_strobe_o === 1'b1) ? 1 : 0);
        if (cyc == 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [BW-1:0] a, input logic [31:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_we_i    <= 1'b0;
        @(posedge core_clk_i);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_get(input logic [BW-1:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_re_i   <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
        @(posedge core_clk_i);
    endtask

    task automatic reg_rd(input logic [BW-1:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        reg_get(a, d);
        check(name, exp, d);
    endtask

    task automatic tape_send(input logic [7:0] c, input logic [1:0] lvl);
        tape_char_i  <= c;
        tape_level_i <= lvl;
        tape_valid_i <= 1'b1;
        @(posedge core_clk_i);
        tape_valid_i <= 1'b0;
        tape_level_i <= LVL_8;
        @(posedge core_clk_i);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic wait_idle();
        v = 32'h0000_0100;
        for (int i = 0; i < 200 && v[9:8] != 2'h0; i++) begin
            reg_get(REG_STAT, v);
        end
    endtask

    task automatic load_wait(input int n, input string name);
        for (int i = 0; i < n && hw_load_o !== 1'b1; i++) begin
            @(posedge core_clk_i);
        end
        check(name, 32'h1, {31'h0, hw_load_o});
    endtask

    task automatic run_at(input logic [AW-1:0] a, input logic [31:0] ctl);
        do_reset();
        reg_wr(REG_PC, {18'h0, a});
        reg_wr(REG_CTRL, ctl);
    endtask

    initial begin
        mem.ram[0]   = 18'h20864;
        mem.ram[1]   = 18'h22065;
        mem.ram[2]   = 18'h29066;
        mem.ram[3]   = 18'h00800;
        mem.ram[4]   = 18'h01800;
        mem.ram[5]   = 18'h02000;
        mem.ram[6]   = 18'h01014;
        mem.ram[7]   = 18'h2306e;
        mem.ram[8]   = 18'h2306e;
        mem.ram[9]   = 18'h2306f;
        mem.ram[10]  = 18'h02000;
        mem.ram[100] = 18'h20005;
        mem.ram[101] = 18'h3fffb;
        mem.ram[102] = 18'h15555;
        mem.ram[110] = 18'h00100;
        mem.ram[111] = 18'h00002;
        do_reset();
        reg_rd(8'h40, 32'h0, "unmapped");
        reg_rd(REG_CTRL, 32'h18, "ctrl reset");
        tape_send(8'ha5, LVL_8);
        check("receive flag", 32'h1, {31'h0, tape_flag_o});
        reg_rd(REG_TAPE, 32'ha5, "buffer zero");
        check("flag cleared", 32'h0, {31'h0, tape_flag_o});
        rx_i <= 21'h1c0006;
        reg_wr(REG_CTRL, 32'h19);
        wait_idle();
        reg_rd(REG_ACCA, 32'h20000, "acc a");
        reg_rd(REG_ACCB, 32'h3, "acc b");
        reg_rd(REG_PC, 32'h6, "pc");
        reg_rd(REG_STAT, 32'h3c, "status");
        check("stored word", 32'h0, {14'h0, mem.ram[102]});
        check("fetch regen", 32'h20864, {14'h0, mem.ram[0]});
        check("transmit", 32'h1c0003, {11'h0, tx_o});
        check("transmit strobes", 32'h1, stb_cnt);
        reg_wr(REG_CIDX, 32'h55);
        check("buffer address", 32'h55, {25'h0, buf_addr_o});
        reg_wr(REG_CTRL, 32'h19);
        load_wait(100, "driver load");
        tape_send(8'h3f, 2'h0);
        tape_send(8'h01, LVL_8);
        tape_send(8'h02, LVL_8);
        tape_send(8'h03, LVL_8);
        repeat (3) @(posedge core_clk_i);
        check("loaded word", 32'h01083, {14'h0, mem.ram[0]});
        tape_end_i <= 1'b1;
        @(posedge core_clk_i);
        tape_end_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check("load ended", 32'h0, {31'h0, hw_load_o});
        do_reset();
        console_load_i <= 1'b1;
        @(posedge core_clk_i);
        console_load_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check("console load", 32'h1, {31'h0, hw_load_o});
        run_at(14'h5, 32'h1b);
        load_wait(20, "halt load");
        run_at(14'h7, 32'h1b);
        load_wait(40, "second count load");
        run_at(14'h9, 32'h1d);
        load_wait(300, "count restart");
        check("interrupts", 32'h1, int_cnt);
        finish_test();
    end
endmodule
